// >>> verilog/fsp_poller.sv
// Contract
// - Status check starts with two back-to-back full-byte reads compared.
// - Toggling with timing-limit high: recheck, then reset if still toggling; the poller only returns FSP_RES_FAIL, reset is a separate command.
// - Polling that pauses restarts from the first double read.
// - After timing-limit failure the host sends reset before array reads.
// - Host may skip erase-window flag only with commands under 50us apart.
// - Check erase-window flag before and after each added sector erase.
// - Data-polling needs valid target address; toggle bit any address.
// - Reset command is one write of F0 to any address.
//
// Flash status poller: APB-controlled host that drives a parallel NOR flash
// bus, issues commands, and runs the toggle-bit and erase-window checks.
// Assumes an APB master on pclk and flash pins wired through an external buffer.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_poller
    import fsp_pkg::*;
#(
    parameter int AW = 17
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic [AW-1:0]      fl_addr,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n,
    input  wire logic [7:0]    fl_dq_in,
    output logic [7:0]         fl_dq_out,
    output logic               fl_dq_oe
);
    initial begin
        if (AW < 15 || AW > 20) $error("fsp_poller: AW out of range");
    end
    typedef struct packed {
        fsp_st_t       st;
        logic [2:0]    cmd;
        logic          go;
        logic [AW-1:0] addr;
        logic [7:0]    wd;
        logic [7:0]    rd;
        logic [7:0]    first;
        logic [2:0]    res;
        logic          busy;
        logic          done;
        logic          bstart;
        logic          bwr;
        logic [AW-1:0] baddr;
        logic [7:0]    bwd;
        logic [7:0]    dq_s1;
        logic [7:0]    dq_s2;
    } fsp_s_t;
    fsp_s_t s_r, s_nxt;
    logic       bdone;
    logic [7:0] brd;
    logic       wr_en;
    logic       toggled;
    fsp_bus_cycle #(.AW(AW)) u_cyc (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (s_r.bstart),
        .wr      (s_r.bwr),
        .addr    (s_r.baddr),
        .wdata   (s_r.bwd),
        .dq_in   (s_r.dq_s2),
        .done    (bdone),
        .rdata   (brd),
        .fl_addr (fl_addr),
        .fl_ce_n (fl_ce_n),
        .fl_oe_n (fl_oe_n),
        .fl_we_n (fl_we_n),
        .dq_out  (fl_dq_out),
        .dq_oe   (fl_dq_oe)
    );
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;
    assign toggled = brd[`FSP_BIT_TOGGLE] != s_r.first[`FSP_BIT_TOGGLE];
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `FSP_OFF_CTRL:  prdata = {29'h0, s_r.cmd};
            `FSP_OFF_ADDR:  prdata = 32'(s_r.addr);
            `FSP_OFF_WDATA: prdata = {24'h0, s_r.wd};
            `FSP_OFF_STAT:  prdata = {27'h0, s_r.res, s_r.done, s_r.busy};
            `FSP_OFF_RDATA: prdata = {24'h0, s_r.rd};
            default:        prdata = 32'h0000_0000;
        endcase
    end
    always_comb begin
        s_nxt        = s_r;
        s_nxt.dq_s1  = fl_dq_in;
        s_nxt.dq_s2  = s_r.dq_s1;
        s_nxt.bstart = 1'b0;
        s_nxt.go     = 1'b0;
        if (wr_en && !s_r.busy) begin
            unique case (paddr)
                `FSP_OFF_CTRL: begin
                    s_nxt.cmd = pwdata[2:0];
                    s_nxt.go  = 1'b1;
                end
                `FSP_OFF_ADDR:  s_nxt.addr = pwdata[AW-1:0];
                `FSP_OFF_WDATA: s_nxt.wd   = pwdata[7:0];
                default: ;
            endcase
        end
        unique case (s_r.st)
            FSP_IDLE: begin
                if (s_r.go) begin
                    s_nxt.busy   = 1'b1;
                    s_nxt.done   = 1'b0;
                    s_nxt.bstart = 1'b1;
                    s_nxt.baddr  = s_r.addr;
                    s_nxt.bwr    = 1'b1;
                    s_nxt.bwd    = s_r.wd;
                    unique case (s_r.cmd)
                        `FSP_CMD_WRITE: s_nxt.st = FSP_EW_CMD;
                        `FSP_CMD_RESET: begin
                            s_nxt.bwd = `FSP_RESET_DATA;
                            s_nxt.st  = FSP_EW_CMD;
                        end
                        `FSP_CMD_READ: begin
                            s_nxt.bwr = 1'b0;
                            s_nxt.st  = FSP_RECHK2;
                        end
                        `FSP_CMD_POLL: begin
                            s_nxt.bwr = 1'b0;
                            s_nxt.st  = FSP_RD1;
                        end
                        `FSP_CMD_SECT_ERS: begin
                            s_nxt.bwr = 1'b0;
                            s_nxt.st  = FSP_EW_PRE;
                        end
                        default: begin
                            s_nxt.bstart = 1'b0;
                            s_nxt.busy   = 1'b0;
                            s_nxt.done   = 1'b1;
                        end
                    endcase
                end
            end
            FSP_RD1: if (bdone) begin
                s_nxt.first  = brd;
                s_nxt.bstart = 1'b1;
                s_nxt.bwr    = 1'b0;
                s_nxt.st     = FSP_RD2;
            end
            FSP_RD2: if (bdone) begin
                if (!toggled) begin
                    s_nxt.res = `FSP_RES_DONE;
                    s_nxt.st  = FSP_IDLE;
                end else if (brd[`FSP_BIT_TLIMIT]) begin
                    s_nxt.first  = brd;
                    s_nxt.bstart = 1'b1;
                    s_nxt.st     = FSP_RECHK1;
                end else begin
                    s_nxt.res = `FSP_RES_BUSY;
                    s_nxt.st  = FSP_IDLE;
                end
            end
            FSP_RECHK1: if (bdone) begin
                s_nxt.res = toggled ? `FSP_RES_FAIL : `FSP_RES_DONE;
                s_nxt.st  = FSP_IDLE;
            end
            FSP_RECHK2: if (bdone) s_nxt.st = FSP_IDLE;
            FSP_EW_PRE: if (bdone) begin
                if (brd[`FSP_BIT_EWIN]) begin
                    s_nxt.res = `FSP_RES_EWIN_ON;
                    s_nxt.st  = FSP_IDLE;
                end else begin
                    s_nxt.bstart = 1'b1;
                    s_nxt.bwr    = 1'b1;
                    s_nxt.st     = FSP_EW_CMD;
                end
            end
            FSP_EW_CMD: if (bdone) begin
                if (s_r.cmd == `FSP_CMD_SECT_ERS) begin
                    s_nxt.bstart = 1'b1;
                    s_nxt.bwr    = 1'b0;
                    s_nxt.st     = FSP_EW_CHK;
                end else begin
                    s_nxt.res = `FSP_RES_DONE;
                    s_nxt.st  = FSP_IDLE;
                end
            end
            FSP_EW_CHK: if (bdone) begin
                s_nxt.res = brd[`FSP_BIT_EWIN] ? `FSP_RES_REJECT : `FSP_RES_DONE;
                s_nxt.st  = FSP_IDLE;
            end
        endcase
        if (s_r.st != FSP_IDLE && s_nxt.st == FSP_IDLE) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.rd   = brd;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: FSP_IDLE, cmd: `FSP_CMD_IDLE, go: 1'b0, addr: '0, wd: 8'h00, rd: 8'h00,
                     first: 8'h00, res: `FSP_RES_DONE, busy: 1'b0, done: 1'b0, bstart: 1'b0,
                     bwr: 1'b0, baddr: '0, bwd: 8'h00, dq_s1: 8'h00, dq_s2: 8'h00};
        end else begin
            s_r <= s_nxt;
        end
    end
    AST_RD2_AFTER_RD1: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_RD1 && bdone) |=> (s_r.st == FSP_RD2 && s_r.bstart)) else $error("no second read");
    AST_FAIL_NEEDS_TL: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_RECHK1 && bdone && toggled) |=> s_r.res == `FSP_RES_FAIL) else $error("fail lost");
    AST_RESET_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_IDLE && s_r.go && s_r.cmd == `FSP_CMD_RESET) |=> s_r.bwd == `FSP_RESET_DATA)
        else $error("reset data wrong");
    AST_EWIN_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_EW_PRE && bdone && brd[`FSP_BIT_EWIN]) |=> (s_r.st == FSP_IDLE && !s_r.bstart))
        else $error("command sent with window closed");
    AST_EWIN_RECHECK: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_EW_CMD && bdone && s_r.cmd == `FSP_CMD_SECT_ERS) |=> s_r.st == FSP_EW_CHK)
        else $error("no post check");
    AST_POLL_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_IDLE && s_r.go && s_r.cmd == `FSP_CMD_POLL) |=> s_r.st == FSP_RD1)
        else $error("poll not restarted");
    AST_DONE_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_RD2 && bdone && !toggled) |=> (s_r.res == `FSP_RES_DONE && s_r.done))
        else $error("done not reported");
    AST_BUSY_NO_TL: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.st == FSP_RD2 && bdone && toggled && !brd[`FSP_BIT_TLIMIT]) |=> s_r.res == `FSP_RES_BUSY)
        else $error("busy not reported");
    COV_POLL_DONE: cover property (@(posedge pclk) s_r.st == FSP_RD2 && bdone && !toggled);
    COV_FAIL: cover property (@(posedge pclk) s_r.st == FSP_RECHK1 && bdone && toggled);
    COV_REJECT: cover property (@(posedge pclk) s_r.st == FSP_EW_CHK && bdone && brd[`FSP_BIT_EWIN]);
endmodule // fsp_poller

// >>> verilog/fsp_params.svh
// Constants for the flash status poller: register map, fields, flash pin timing.
// Assumes inclusion by the design modules and the test bench; definitions only.
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
`define FSP_OFF_CTRL      12'h000
`define FSP_OFF_ADDR      12'h004
`define FSP_OFF_WDATA     12'h008
`define FSP_OFF_STAT      12'h00c
`define FSP_OFF_RDATA     12'h010
`define FSP_CMD_IDLE      3'h0
`define FSP_CMD_WRITE     3'h1
`define FSP_CMD_READ      3'h2
`define FSP_CMD_POLL      3'h3
`define FSP_CMD_RESET     3'h4
`define FSP_CMD_SECT_ERS  3'h5
`define FSP_RESET_DATA    8'hf0
`define FSP_BIT_POLL      7
`define FSP_BIT_TOGGLE    6
`define FSP_BIT_TLIMIT    5
`define FSP_BIT_EWIN      3
`define FSP_CYC_NS        4
`define FSP_PULSE_NS      100
`define FSP_PULSE_CYC     ((`FSP_PULSE_NS + `FSP_CYC_NS - 1) / `FSP_CYC_NS)
`define FSP_RES_DONE      3'h0
`define FSP_RES_BUSY      3'h1
`define FSP_RES_FAIL      3'h2
`define FSP_RES_EWIN_ON   3'h3
`define FSP_RES_REJECT    3'h4
`endif

// >>> verilog/fsp_pkg.sv
// Types shared by the flash status poller modules.
// Assumes fsp_params.svh holds the numeric constants.
package fsp_pkg;
    typedef enum logic [3:0] {
        FSP_BUS_IDLE  = 4'b0001,
        FSP_BUS_SETUP = 4'b0010,
        FSP_BUS_PULSE = 4'b0100,
        FSP_BUS_DONE  = 4'b1000
    } fsp_bus_st_t;
    typedef enum logic [7:0] {
        FSP_IDLE   = 8'b0000_0001,
        FSP_RD1    = 8'b0000_0010,
        FSP_RD2    = 8'b0000_0100,
        FSP_RECHK1 = 8'b0000_1000,
        FSP_RECHK2 = 8'b0001_0000,
        FSP_EW_PRE = 8'b0010_0000,
        FSP_EW_CMD = 8'b0100_0000,
        FSP_EW_CHK = 8'b1000_0000
    } fsp_st_t;
endpackage

// >>> verilog/fsp_bus_cycle.sv
// One asynchronous flash bus cycle: read or write strobe of fixed width.
// Assumes the flash data pins reach dq_in already through two flip-flops.
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_bus_cycle
    import fsp_pkg::*;
#(
    parameter int AW = 17
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          start,
    input  wire logic          wr,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic [7:0]    dq_in,
    output logic               done,
    output logic [7:0]         rdata,
    output logic [AW-1:0]      fl_addr,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n,
    output logic [7:0]         dq_out,
    output logic               dq_oe
);
    localparam logic [7:0] PULSE = 8'(`FSP_PULSE_CYC);
    initial begin
        if (AW < 15 || AW > 20) $error("fsp_bus_cycle: AW out of range");
    end
    typedef struct packed {
        fsp_bus_st_t   st;
        logic [7:0]    cnt;
        logic          wr;
        logic [AW-1:0] addr;
        logic [7:0]    wd;
        logic [7:0]    rd;
    } fsp_bc_t;
    fsp_bc_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            FSP_BUS_IDLE: begin
                if (start) begin
                    s_nxt.st   = FSP_BUS_SETUP;
                    s_nxt.wr   = wr;
                    s_nxt.addr = addr;
                    s_nxt.wd   = wdata;
                end
            end
            FSP_BUS_SETUP: begin
                s_nxt.st  = FSP_BUS_PULSE;
                s_nxt.cnt = PULSE;
            end
            FSP_BUS_PULSE: begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                if (s_r.cnt == 8'h01) begin
                    s_nxt.st = FSP_BUS_DONE;
                    // Sample just before strobe release; dq_in lags the pins by two flip-flops, so it shows them two cycles before the pulse ends
                    s_nxt.rd = dq_in;
                end
            end
            FSP_BUS_DONE: s_nxt.st = FSP_BUS_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: FSP_BUS_IDLE, cnt: 8'h00, wr: 1'b0, addr: '0, wd: 8'h00, rd: 8'h00};
        end else begin
            s_r <= s_nxt;
        end
    end
    // Each read is a full CE/OE cycle, so successive status reads are distinct
    assign done    = (s_r.st == FSP_BUS_DONE);
    assign rdata   = s_r.rd;
    assign fl_addr = s_r.addr;
    assign fl_ce_n = !(s_r.st == FSP_BUS_PULSE);
    assign fl_oe_n = !(s_r.st == FSP_BUS_PULSE && !s_r.wr);
    assign fl_we_n = !(s_r.st == FSP_BUS_PULSE && s_r.wr);
    assign dq_out  = s_r.wd;
    assign dq_oe   = s_r.wr && (s_r.st != FSP_BUS_IDLE);
    AST_NO_OVERLAP: assert property (@(posedge pclk) disable iff (!presetn)
        !(!fl_oe_n && !fl_we_n)) else $error("oe and we low together");
    AST_PULSE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fl_ce_n) |-> !fl_ce_n [*8]) else $error("strobe too short");
endmodule // fsp_bus_cycle

// >>> testbench/fsp_flash_model.sv
// Behavioural parallel flash: small array, program, sector-erase window, status bits.
// Assumes a host that holds ce/oe/we low for a whole read or write cycle.
`timescale 1ns/10ps
module fsp_flash_model #(
    parameter int AW    = 17,
    parameter int PROGN = 3,
    parameter int EWINN = 6,
    parameter int ERSN  = 4
) (
    input  wire logic [AW-1:0] fl_addr,
    input  wire logic          fl_ce_n,
    input  wire logic          fl_oe_n,
    input  wire logic          fl_we_n,
    input  wire logic [7:0]    host_dq,
    input  wire logic          host_oe,
    output logic [7:0]         bus_dq
);
    typedef enum logic [2:0] {FM_ARR, FM_PROG, FM_FAIL, FM_EWIN, FM_ERS} fsp_fm_t;
    fsp_fm_t       st     = FM_ARR;
    logic [7:0]    mem [16];
    logic [7:0]    wd     = 8'hf0;
    logic [7:0]    pd     = 8'h00;
    logic [7:0]    last_v = 8'h00;
    logic [7:0]    mdq;
    logic [AW-1:0] wa     = '0;
    logic          tog    = 1'b0;
    int            cnt    = 0;
    wire rd = !fl_ce_n && !fl_oe_n && fl_we_n;
    wire wr = !fl_ce_n && !fl_we_n;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'hff;
    end
    // Upper half of the array is protected
    always @* begin
        if (st == FM_ARR) mdq = mem[fl_addr[3:0]];
        else mdq = {st == FM_PROG ? ~pd[7] : 1'b0, tog, st == FM_FAIL, 1'b0, st == FM_ERS, 3'h0};
    end
    // Undriven bus shows the inverse of its last value, never a kind constant
    assign bus_dq = host_oe ? host_dq : (rd ? mdq : ~last_v);
    always @* if (wr) begin
        wa = fl_addr;
        wd = host_dq;
    end
    always @(negedge wr) begin
        last_v <= wd;
        if (st == FM_ERS) ;
        else if (wd == 8'hf0) st <= FM_ARR;
        else if (st == FM_ARR && wd == 8'h30) begin
            st  <= FM_EWIN;
            cnt <= EWINN;
        end
        else if (st == FM_EWIN && wd == 8'h30) cnt <= EWINN;
        else if (st == FM_ARR) begin
            pd  <= wd;
            st  <= FM_PROG;
            cnt <= PROGN;
            if (wa[3]) cnt <= 2;
            else if ((wd & ~mem[wa[3:0]]) != 8'h00) st <= FM_FAIL;
            else mem[wa[3:0]] <= wd;
        end
    end
    always @(negedge rd) begin
        last_v <= mdq;
        if (st != FM_ARR) tog <= ~tog;
        cnt <= cnt - 1;
        if ((st == FM_PROG || st == FM_ERS) && cnt == 1) st <= FM_ARR;
        if (st == FM_EWIN && cnt == 1) begin
            st  <= FM_ERS;
            cnt <= ERSN;
            // A protected target only toggles through the erase time, then reverts
            if (!wa[3]) for (int i = 0; i < 8; i++) mem[i] <= 8'hff;
        end
    end
endmodule // fsp_flash_model

// >>> testbench/fsp_poller_test.sv
// Self-checking bench for the flash status poller, APB master and flash model.
// Assumes the design's zero-wait APB slave and the behavioural flash partner.
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_poller_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
    logic [16:0] fl_addr;
    logic [7:0]  fl_dq_in, fl_dq_out;
    logic [31:0] q, st;
    int          err_total = 0, compares = 0;
    always #2 pclk = ~pclk;
    fsp_poller #(.AW(17)) fsp_poller_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_in(fl_dq_in),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));
    fsp_flash_model #(.AW(17)) fsp_flash_model_inst (.fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n), .host_dq(fl_dq_out), .host_oe(fl_dq_oe), .bus_dq(fl_dq_in));
    task report_and_stop;
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            $display("MISMATCH %0t no pready", $time);
            report_and_stop;
        end
        r = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task cmd(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d, output logic [31:0] s);
        logic [31:0] r;
        int n;
        apb(1'b1, `FSP_OFF_ADDR, {15'h0, a}, r);
        apb(1'b1, `FSP_OFF_WDATA, {24'h0, d}, r);
        apb(1'b1, `FSP_OFF_CTRL, {29'h0, c}, r);
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 400) begin
            apb(1'b0, `FSP_OFF_STAT, 32'h0, s);
            n++;
        end
        if (n >= 400) begin
            err_total++;
            $display("MISMATCH %0t command hang", $time);
            report_and_stop;
        end
    endtask
    task rd_byte(input logic [16:0] a, output logic [31:0] r);
        logic [31:0] s;
        cmd(`FSP_CMD_READ, a, 8'h00, s);
        apb(1'b0, `FSP_OFF_RDATA, 32'h0, r);
    endtask
    task poll_done;
        int n;
        n = 0;
        do begin
            cmd(`FSP_CMD_POLL, 17'h0, 8'h00, st);
            n++;
        end while (st[4:2] === 3'h1 && n < 8);
        chk({29'h0, st[4:2]}, 32'h0);
    endtask
    task t_reset_regs;
        apb(1'b0, `FSP_OFF_STAT, 32'h0, q);
        chk(q, 32'h0);
        apb(1'b0, `FSP_OFF_RDATA, 32'h0, q);
        chk(q, 32'h0);
        apb(1'b0, 12'h020, 32'h0, q);
        chk({q[31:1], pslverr}, 32'h0);
    endtask
    task t_program;
        cmd(`FSP_CMD_WRITE, 17'h1, 8'h3c, st);
        rd_byte(17'h1, q);
        chk({30'h0, q[7], q[5]}, 32'h2);
        cmd(`FSP_CMD_POLL, 17'h0, 8'h00, st);
        chk({29'h0, st[4:2]}, 32'h1);
        poll_done();
        rd_byte(17'h1, q);
        chk(q, 32'h3c);
    endtask
    task t_protected;
        cmd(`FSP_CMD_WRITE, 17'h8, 8'h00, st);
        cmd(`FSP_CMD_POLL, 17'h0, 8'h00, st);
        chk({29'h0, st[4:2]}, 32'h1);
        poll_done();
        rd_byte(17'h8, q);
        chk(q, 32'hff);
    endtask
    task t_fail_reset;
        // Setting a stored zero back to one can only fail
        cmd(`FSP_CMD_WRITE, 17'h1, 8'hff, st);
        cmd(`FSP_CMD_POLL, 17'h0, 8'h00, st);
        chk({29'h0, st[4:2]}, 32'h2);
        cmd(`FSP_CMD_RESET, 17'h5, 8'h00, st);
        rd_byte(17'h1, q);
        chk(q, 32'h3c);
    endtask
    task t_erase_window;
        cmd(`FSP_CMD_WRITE, 17'h0, 8'h30, st);
        cmd(`FSP_CMD_SECT_ERS, 17'h0, 8'h30, st);
        chk({29'h0, st[4:2]}, 32'h0);
        for (int i = 0; i < 4; i++) rd_byte(17'h2, q);
        // Window closes between the two probes: the pre-check read ends its count, so the add is ignored
        cmd(`FSP_CMD_SECT_ERS, 17'h0, 8'h30, st);
        chk({29'h0, st[4:2]}, 32'h4);
        cmd(`FSP_CMD_SECT_ERS, 17'h0, 8'h30, st);
        chk({29'h0, st[4:2]}, 32'h3);
        poll_done();
        rd_byte(17'h1, q);
        chk(q, 32'hff);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_regs();
        t_program();
        t_protected();
        t_fail_reset();
        t_erase_window();
        report_and_stop;
    end
endmodule // fsp_poller_test
